// File: design/gpio_consts.svh
// Offsets, field positions, capability masks and reset values of the port block
`ifndef GPIO_CONSTS_SVH
`define GPIO_CONSTS_SVH
// ----------------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------------
`define GP_NPORTS 15
`define GP_PW 8
`define GP_NPINS 120
// ----------------------------------------------------------------------------
// Register map: port index in haddr[8:5], register in haddr[4:2]
// ----------------------------------------------------------------------------
`define GP_PORT_STRIDE 32'h0000_0020
`define GP_OFS_DIR 3'h0
`define GP_OFS_LATCH 3'h1
`define GP_OFS_PULLUP 3'h2
`define GP_OFS_ODRAIN 3'h3
`define GP_OFS_PINS 3'h4
`define GP_OFS_ALTSEL 3'h5
// ----------------------------------------------------------------------------
// Capability masks, bit n is port index n
// Order: 1,2,3,4,5,9,A,B,C,D,E,F,H,J,K
// ----------------------------------------------------------------------------
`define GP_HAS_DIR 15'h7fd7
`define GP_HAS_PULLUP 15'h07c0
`define GP_HAS_ODRAIN 15'h01c4
`define GP_RESET_BYTE 8'h00
`endif

// File: design/gpio_pkg.sv
// Types shared by the general purpose port block
package gpio_pkg;
   typedef logic [7:0] port_byte_t;
   typedef logic [3:0] port_idx_t;
   typedef logic [2:0] reg_sel_t;
endpackage

// File: design/gpio_ports.sv
// General purpose I/O port block with an AHB-Lite register slave
//
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "gpio_consts.svh"

// Behaviour
// R01 - Thirteen bidirectional ports, two input-only ports
// R02 - Per-pin direction register selects input/output
// R03 - Output latch holds driven pin value
// R04 - Read-only pin register returns live levels
// R05 - Input-only ports lack direction and latch
// R06 - Ports A-E carry per-pin pull-up control
// R07 - Ports 3, A-C carry open-drain control
// R08 - Every pin muxed with peripheral function
// R09 - Direction one drives latch; resets to input
module gpio_ports
   import gpio_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [119:0] pin_in,
   output logic [119:0] pin_out,
   output logic [119:0] pin_oe,
   output logic [119:0] pullup_en,
   input wire logic [119:0] alt_out,
   input wire logic [119:0] alt_oe
);

   // -------------------------------------------------------------------------
   // Bus slave: address phase capture
   // -------------------------------------------------------------------------
   logic ap_valid_q; // Data phase pending
   logic ap_write_q; // Pending transfer is a write
   logic ap_map_q; // Address falls inside the map
   port_idx_t ap_port_q; // Port index of pending transfer
   reg_sel_t ap_reg_q; // Register select of pending transfer
   logic hready_q; // Registered hreadyout
   logic [31:0] hrdata_q; // Registered read data

   wire take = hsel & hready & htrans[1];
   // Upper address bits must be zero and port/register indices in range
   wire addr_map = (haddr[31:9] == 23'h00_0000) && (haddr[8:5] < 4'hf) && (haddr[4:2] <= 3'h5);
   wire wr_now = ap_valid_q & ap_write_q & ap_map_q;
   wire rd_now = ap_valid_q & ~ap_write_q;

   // Address phase register; hsize is accepted but only words are expected
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_valid_q <= 1'b0;
         ap_write_q <= 1'b0;
         ap_map_q <= 1'b0;
         ap_port_q <= 4'h0;
         ap_reg_q <= 3'h0;
      end else if (take) begin
         ap_valid_q <= 1'b1;
         ap_write_q <= hwrite;
         ap_map_q <= addr_map;
         ap_port_q <= haddr[8:5];
         ap_reg_q <= haddr[4:2];
      end else if (hready_q) begin
         // Data phase completes whenever hreadyout is high
         ap_valid_q <= 1'b0;
      end
   end

   // -------------------------------------------------------------------------
   // Per-port registers and pin drive
   // -------------------------------------------------------------------------
   port_byte_t rd_byte [`GP_NPORTS]; // Read value of selected register, per port
   logic [119:0] oe_d; // Next output enables
   logic [119:0] out_d; // Next output values
   logic [119:0] pu_d; // Next pull-up enables

   // Capability masks as vectors so each port can pick its own bit
   localparam logic [14:0] has_dir_mask = `GP_HAS_DIR;
   localparam logic [14:0] has_pu_mask = `GP_HAS_PULLUP;
   localparam logic [14:0] has_od_mask = `GP_HAS_ODRAIN;

   genvar p;
   generate
      for (p = 0; p < `GP_NPORTS; p++) begin : g_port
         port_byte_t dir_q; // 1 = output
         port_byte_t latch_q; // Output latch
         port_byte_t pu_q; // Pull-up enables
         port_byte_t od_q; // Open-drain enables
         port_byte_t alt_q; // 1 = peripheral owns pin
         wire sel = ap_map_q && (ap_port_q == 4'(p));
         // Writes to missing registers are dropped by the capability masks
         wire we_dir = wr_now & sel & (ap_reg_q == `GP_OFS_DIR) & has_dir_mask[p]; // [R05]
         wire we_lat = wr_now & sel & (ap_reg_q == `GP_OFS_LATCH) & has_dir_mask[p]; // [R05]
         wire we_pu = wr_now & sel & (ap_reg_q == `GP_OFS_PULLUP) & has_pu_mask[p]; // [R06]
         wire we_od = wr_now & sel & (ap_reg_q == `GP_OFS_ODRAIN) & has_od_mask[p]; // [R07]
         wire we_alt = wr_now & sel & (ap_reg_q == `GP_OFS_ALTSEL);
         // Pin value and enable before the open-drain cut
         wire [7:0] val = (alt_q & alt_out[p*8 +: 8]) | (~alt_q & latch_q); // [R03] [R08]
         wire [7:0] en = (alt_q & alt_oe[p*8 +: 8]) | (~alt_q & dir_q); // [R02] [R08] [R09]

         // Control registers; direction resets to input
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               dir_q <= `GP_RESET_BYTE; // [R09]
               latch_q <= `GP_RESET_BYTE;
               pu_q <= `GP_RESET_BYTE;
               od_q <= `GP_RESET_BYTE;
               alt_q <= `GP_RESET_BYTE;
            end else begin
               if (we_dir) dir_q <= hwdata[7:0]; // [R02]
               if (we_lat) latch_q <= hwdata[7:0]; // [R03]
               if (we_pu) pu_q <= hwdata[7:0]; // [R06]
               if (we_od) od_q <= hwdata[7:0]; // [R07]
               if (we_alt) alt_q <= hwdata[7:0]; // [R08]
            end
         end

         // Open drain turns off the high side: a one releases the pin
         assign oe_d[p*8 +: 8] = has_dir_mask[p] ? (en & ~(od_q & val)) : 8'h00; // [R01] [R07]
         assign out_d[p*8 +: 8] = has_dir_mask[p] ? val : 8'h00;
         // Pull-up only makes sense while the pin is not driven
         assign pu_d[p*8 +: 8] = pu_q & ~en; // [R06]
         // Read path; missing registers read as zero
         assign rd_byte[p] = (ap_reg_q == `GP_OFS_DIR) ? dir_q :
                             (ap_reg_q == `GP_OFS_LATCH) ? latch_q :
                             (ap_reg_q == `GP_OFS_PULLUP) ? pu_q :
                             (ap_reg_q == `GP_OFS_ODRAIN) ? od_q :
                             (ap_reg_q == `GP_OFS_PINS) ? pin_in[p*8 +: 8] : // [R04]
                             alt_q;
      end
   endgenerate

   wire [7:0] rd_sel = ap_map_q ? rd_byte[ap_port_q] : 8'h00; // Unmapped reads zero

   // -------------------------------------------------------------------------
   // Read data and wait state; reads take one wait so hrdata comes from a flop
   // -------------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hready_q <= 1'b1;
         hrdata_q <= 32'h0000_0000;
      end else if (take && !hwrite) begin
         hready_q <= 1'b0;
      end else if (rd_now && !hready_q) begin
         hready_q <= 1'b1;
         hrdata_q <= {24'h00_0000, rd_sel}; // [R04]
      end
   end

   // Pin outputs registered so every top output comes from a flop
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_out <= 120'h0;
         pin_oe <= 120'h0;
         pullup_en <= 120'h0;
      end else begin
         pin_out <= out_d;
         pin_oe <= oe_d;
         pullup_en <= pu_d;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) hresp <= 1'b0;
      else hresp <= 1'b0; // Always OKAY
   end

   assign hrdata = hrdata_q;
   assign hreadyout = hready_q;

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   wire [7:0] pin_ref = pin_in[ap_port_q*8 +: 8]; // Independent pin pick for checks
   wire rd_pins = rd_now & ~hready_q & ap_map_q & (ap_reg_q == `GP_OFS_PINS);
   wire rd_dir_in = rd_now & ~hready_q & ap_map_q & (ap_reg_q == `GP_OFS_DIR)
                    & ((ap_port_q == 4'h3) | (ap_port_q == 4'h5));

   sequence s_dir_write;
      wr_now && ap_reg_q == `GP_OFS_DIR && ap_port_q == 4'h0 && hwdata[0];
   endsequence
   sequence s_pin0_drives;
      ##2 pin_oe[0] || g_port[0].alt_q[0] || g_port[0].od_q[0];
   endsequence

   property p_r01;
      pin_oe[31:24] == 8'h00 && pin_oe[47:40] == 8'h00;
   endproperty
   a_r01: assert property (p_r01) else $error("input-only port drives"); // [R01]

   property p_r02;
      (g_port[1].dir_q[2] && !g_port[1].alt_q[2]) |=> pin_oe[10];
   endproperty
   a_r02: assert property (p_r02) else $error("output pin not enabled"); // [R02]

   property p_r03;
      !g_port[0].alt_q[5] |=> pin_out[5] == $past(g_port[0].latch_q[5]);
   endproperty
   a_r03: assert property (p_r03) else $error("pin does not follow latch"); // [R03]

   property p_r04;
      rd_pins |=> hready_q && hrdata_q[7:0] == $past(pin_ref);
   endproperty
   a_r04: assert property (p_r04) else $error("pin read mismatch"); // [R04]

   property p_r05;
      rd_dir_in |=> hrdata_q == 32'h0000_0000;
   endproperty
   a_r05: assert property (p_r05) else $error("input-only port has direction"); // [R05]

   property p_r06;
      pullup_en[47:0] == 48'h0 && pullup_en[119:88] == 32'h0;
   endproperty
   a_r06: assert property (p_r06) else $error("pull-up on unsupported port"); // [R06]

   property p_r07;
      (g_port[6].od_q[1] && out_d[49]) |=> !pin_oe[49];
   endproperty
   a_r07: assert property (p_r07) else $error("open drain drove high"); // [R07]

   // Port 0 is the one whose peripheral select the bench exercises
   property p_r08;
      g_port[0].alt_q[4] |=> pin_out[4] == $past(alt_out[4]) && pin_oe[4] ==
         ($past(alt_oe[4]) && !($past(g_port[0].od_q[4]) && $past(alt_out[4])));
   endproperty
   a_r08: assert property (p_r08) else $error("peripheral not routed"); // [R08]

   property p_r09;
      s_dir_write |-> s_pin0_drives;
   endproperty
   a_r09: assert property (p_r09) else $error("direction write did not drive"); // [R09]

endmodule

// File: bench/pin_board.sv
// Board side model of the port pins: drivers, pull-ups and external levels
`timescale 1ns/10ps
module pin_board (
   input wire logic [119:0] pin_out,
   input wire logic [119:0] pin_oe,
   input wire logic [119:0] pullup_en,
   input wire logic [119:0] ext,
   output logic [119:0] pin_in
);
   // ---------------------------------------------------------------------------
   // Pin level
   // ---------------------------------------------------------------------------
   // Driven pin follows the block; a released pin sees the pull-up or the board
   // level, which the bench redraws at random each round, so a stale value is unlikely to read back by luck
   assign pin_in = pin_oe & pin_out | ~pin_oe & pullup_en
                   | ~pin_oe & ~pullup_en & ext;
endmodule

// File: bench/general_purpose_io_ports_tb.sv
// Self-checking bench for the general purpose port block
`timescale 1ns/10ps
`include "gpio_consts.svh"
module general_purpose_io_ports_tb
   import gpio_pkg::*;
;
   // ---------------------------------------------------------------------------
   // Signals, register model and helpers
   // ---------------------------------------------------------------------------
   localparam logic [14:0] has_dir = `GP_HAS_DIR;
   localparam logic [14:0] has_pu = `GP_HAS_PULLUP;
   localparam logic [14:0] has_od = `GP_HAS_ODRAIN;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rd_ph;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [119:0] pin_in, pin_out, pin_oe, pullup_en, alt_out, alt_oe, ext, pin_exp;
   logic [127:0] r128;
   port_byte_t dir_m[15], lat_m[15], pu_m[15], od_m[15], alt_m;
   logic [31:0] exp_q[$];
   int n_fail, checks, seed;
   gpio_ports dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en), .alt_out(alt_out),
      .alt_oe(alt_oe));
   pin_board board (.pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en), .ext(ext),
      .pin_in(pin_in));
   // Clock at 200 MHz
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   task automatic end_sim();
      // Notes never matched by a read count as misses
      n_fail += exp_q.size();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic cmp(input logic [119:0] got, input logic [119:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Read data and bus response check
   task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Bounded wait for hready; a hang ends the run as a mismatch
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 40);
      if (hreadyout !== 1'b1) begin
         n_fail++;
         end_sim();
      end
   endtask
   // One single word transfer; entered right after a rising edge
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                       input logic [31:0] e);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      wait_rdy();
      htrans <= 2'b00;
      hwdata <= d;
      if (!w) exp_q.push_back(e);
      wait_rdy();
   endtask
   task automatic wr(input logic [31:0] a, input port_byte_t d);
      xfer(1'b1, a, {24'h00_0000, d}, 32'h0000_0000);
   endtask
   task automatic rd(input logic [31:0] a, input port_byte_t e);
      xfer(1'b0, a, 32'h0000_0000, {24'h00_0000, e});
   endtask
   function automatic logic [31:0] ra(input int p, input int r);
      return p * `GP_PORT_STRIDE + r * 4;
   endfunction
   function automatic port_byte_t rb();
      logic [31:0] v;
      v = $random(seed);
      return v[7:0];
   endfunction
   // Read monitor: oldest note taken off the queue when read data stands
   always @(posedge hclk) begin
      if (rd_ph && hreadyout === 1'b1 && exp_q.size() > 0) begin
         cmp_rd(hrdata, exp_q.pop_front());
         cmp_rd({31'h0000_0000, hresp}, 32'h0000_0000);
      end
      if (hreadyout === 1'b1)
         rd_ph <= hsel && htrans[1] && !hwrite;
   end
   // Pin expectations from the model; released pins read back the pull-up or the board level
   task automatic chk_pins();
      logic [119:0] o, e, u;
      port_byte_t dr, lt, op, oep;
      for (int p = 0; p < 15; p++) begin
         dr = has_dir[p] ? dir_m[p] : 8'h00;
         lt = has_dir[p] ? lat_m[p] : 8'h00;
         op = (p == 0) ? (alt_m & alt_out[7:0] | ~alt_m & lt) : lt;
         oep = (p == 0) ? (alt_m & alt_oe[7:0] | ~alt_m & dr) : dr;
         o[p*8 +: 8] = op;
         u[p*8 +: 8] = (has_pu[p] ? pu_m[p] : 8'h00) & ~oep;
         e[p*8 +: 8] = oep & ~((has_od[p] ? od_m[p] : 8'h00) & op);
      end
      pin_exp = e & o | ~e & u | ~e & ~u & ext;
      cmp(pin_out, o);
      cmp(pin_oe, e);
      cmp(pullup_en, u);
      for (int p = 0; p < 15; p++)
         rd(ra(p, 4), pin_exp[p*8 +: 8]);
   endtask
   task automatic rd_all();
      for (int p = 0; p < 15; p++) begin
         rd(ra(p, 0), has_dir[p] ? dir_m[p] : 8'h00);
         rd(ra(p, 1), has_dir[p] ? lat_m[p] : 8'h00);
         rd(ra(p, 2), has_pu[p] ? pu_m[p] : 8'h00);
         rd(ra(p, 3), has_od[p] ? od_m[p] : 8'h00);
      end
      rd(ra(0, 5), alt_m);
   endtask
   // ---------------------------------------------------------------------------
   // Main sequence: reset, random rounds, unmapped places, second reset
   // ---------------------------------------------------------------------------
   initial begin
      {hresetn, hsel, hwrite, rd_ph, htrans, haddr, hwdata} = '0;
      {ext, alt_out, alt_oe, alt_m} = '0;
      hsize = 3'h2;
      seed = 72;
      n_fail = 0;
      checks = 0;
      for (int p = 0; p < 15; p++) {dir_m[p], lat_m[p], pu_m[p], od_m[p]} = '0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk_pins();
      rd_all();
      // Random settings, including writes to missing and read-only places
      repeat (4) begin
         for (int p = 0; p < 15; p++) begin
            dir_m[p] = rb();
            lat_m[p] = rb();
            pu_m[p] = rb();
            od_m[p] = rb();
            wr(ra(p, 0), dir_m[p]);
            wr(ra(p, 1), lat_m[p]);
            wr(ra(p, 2), pu_m[p]);
            wr(ra(p, 3), od_m[p]);
            wr(ra(p, 4), rb());
         end
         alt_m = rb();
         wr(ra(0, 5), alt_m);
         r128 = {$random(seed), $random(seed), $random(seed), $random(seed)};
         ext <= r128[119:0];
         alt_out <= ~r128[119:0];
         alt_oe <= {r128[59:0], r128[119:60]};
         repeat (2) @(posedge hclk);
         chk_pins();
         rd_all();
      end
      // Unmapped places: writes ignored, reads zero, no aliasing onto port 0
      wr(32'h0000_0200, 8'hff);
      wr(ra(15, 0), 8'hff);
      wr(ra(0, 6), 8'hff);
      rd(32'h0000_0200, 8'h00);
      rd(ra(15, 0), 8'h00);
      rd(ra(0, 6), 8'h00);
      rd_all();
      // Reset in mid-run returns every pin to input
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int p = 0; p < 15; p++) {dir_m[p], lat_m[p], pu_m[p], od_m[p]} = '0;
      alt_m = 8'h00;
      chk_pins();
      rd_all();
      // Let the monitor take the last read before the verdict
      @(posedge hclk);
      end_sim();
   end
endmodule
